// file: aams_pkg.sv
package aams_pkg;

  // register addresses on the special function register bus
  localparam logic [7:0] TEMP_RESULT_ADDR  = 8'hD7;
  localparam logic [7:0] CONV_REQUEST_ADDR = 8'hD8;
  localparam logic [7:0] BATT_RESULT_ADDR  = 8'hDF;
  localparam logic [7:0] EXT_RESULT_ADDR   = 8'hEF;
  localparam logic [7:0] DELTA_CFG_ADDR    = 8'hF3;
  localparam logic [7:0] INTERVAL_ADDR     = 8'hF9;
  localparam logic [7:0] BATT_THRESH_ADDR  = 8'hFA;

  // reset values
  localparam logic [7:0] RESULT_RESET      = 8'h00;
  localparam logic [7:0] CONV_REQUEST_RESET = 8'h00;
  localparam logic [7:0] DELTA_CFG_RESET   = 8'h00;
  localparam logic [7:0] INTERVAL_RESET    = 8'h00;
  localparam logic [7:0] BATT_THRESH_RESET = 8'h00;

  // sensor index doubles as the one-shot bit position
  localparam int SENSOR_BATT = 0;
  localparam int SENSOR_TEMP = 1;
  localparam int SENSOR_EXT  = 2;
  localparam int NUM_SENSORS = 3;

  // field positions
  localparam int PLL_ACK_BIT        = 7;
  localparam int EXT_INTERVAL_LSB   = 4;
  localparam int BATT_INTERVAL_LSB  = 2;
  localparam int TEMP_INTERVAL_LSB  = 0;
  localparam int TEMP_DELTA_LSB     = 3;
  localparam int EXT_DELTA_LSB      = 0;
  localparam logic [7:0] INTERVAL_USED_MASK = 8'h3F;
  localparam logic [7:0] DELTA_USED_MASK    = 8'h3F;

  // delta field codes
  localparam logic [2:0] DELTA_OFF   = 3'h0;
  localparam logic [2:0] DELTA_EVERY = 3'h7;

  // slow time base: one tick per second
  localparam logic [5:0] SECONDS_PER_MINUTE = 6'h3C;

  // interval lengths in minutes
  localparam logic [4:0] EXT_LONG_MIN  = 5'h08;
  localparam logic [4:0] EXT_MID_MIN   = 5'h02;
  localparam logic [4:0] BATT_LONG_MIN = 5'h10;
  localparam logic [4:0] BATT_MID_MIN  = 5'h04;
  localparam logic [4:0] TEMP_LONG_MIN = 5'h08;
  localparam logic [4:0] TEMP_MID_MIN  = 5'h02;
  localparam logic [4:0] SHORT_MIN     = 5'h01;

  typedef enum logic [1:0] {
    AAMS_IDLE = 2'b00,
    AAMS_REQ  = 2'b01,
    AAMS_BUSY = 2'b11
  } aams_conv_state_e;

  function automatic logic [4:0] interval_minutes(
    input logic [1:0] code,
    input logic [4:0] long_min,
    input logic [4:0] mid_min
  );
    case (code)
      2'h1:    interval_minutes = long_min;
      2'h2:    interval_minutes = mid_min;
      2'h3:    interval_minutes = SHORT_MIN;
      default: interval_minutes = 5'h00;
    endcase
  endfunction

endpackage

// file: aams_interval_timer.sv
`timescale 1ns/10ps
`default_nettype none
module aams_interval_timer #(
  parameter logic [4:0] LONG_MIN = 5'h08,
  parameter logic [4:0] MID_MIN  = 5'h02
) (
  input  wire logic       clock,
  input  wire logic       reset_n,
  input  wire logic       minute_pulse,
  input  wire logic [1:0] interval_code,
  input  wire logic       enable,
  output var  logic       strobe
);

  logic [4:0] period;
  logic [4:0] count_reg;
  logic [1:0] code_reg;

  assign period = aams_pkg::interval_minutes(interval_code, LONG_MIN,
                                             MID_MIN);

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      count_reg <= 5'h00;
      code_reg  <= 2'h0;
      strobe    <= 1'b0;
    end else begin
      code_reg <= interval_code;
      strobe   <= 1'b0;
      // a new interval restarts the minute count so the first strobe comes on
      // the period-th minute_pulse after the change
      if (interval_code == 2'h0 || interval_code != code_reg) begin
        count_reg <= 5'h00;
      end else if (minute_pulse) begin
        if (count_reg + 5'h01 >= period) begin
          count_reg <= 5'h00;
          strobe    <= enable;
        end else begin
          count_reg <= count_reg + 5'h01;
        end
      end
    end
  end

endmodule
`default_nettype wire

// file: aams_change_tracker.sv
`timescale 1ns/10ps
`default_nettype none
module aams_change_tracker #(
  parameter bit THRESHOLD_MODE = 1'b0
) (
  input  wire logic       clock,
  input  wire logic       reset_n,
  input  wire logic       done,
  input  wire logic       from_oneshot,
  input  wire logic [7:0] data,
  input  wire logic [2:0] delta_code,
  input  wire logic [7:0] threshold,
  output var  logic       load,
  output var  logic [7:0] value
);

  logic [7:0] last_reg;
  logic [7:0] diff;
  logic       hit;

  assign diff = (data > last_reg) ? data - last_reg : last_reg - data;

  always_comb begin
    if (THRESHOLD_MODE) begin
      hit = data < threshold;
    end else begin
      hit = (delta_code == aams_pkg::DELTA_EVERY) ||
            ((delta_code != aams_pkg::DELTA_OFF) &&
             (diff > {5'h00, delta_code}));
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      last_reg <= aams_pkg::RESULT_RESET;
      value    <= aams_pkg::RESULT_RESET;
      load     <= 1'b0;
    end else begin
      load <= done && (hit || from_oneshot);
      if (done) begin
        value <= data;
      end
      // the reference only moves on an interrupting result
      if (done && (hit || from_oneshot)) begin
        last_reg <= data;
      end
    end
  end

endmodule
`default_nettype wire

// file: aams_measurement_scheduler.sv
// How it works
// - Bits 5:4 pick external voltage background interval: off, 8, 2, 1 minutes.
// - Bits 3:2 pick battery background interval: off, 16, 4, 1 minutes.
// - Bits 1:0 pick temperature background interval: off, 8, 2, 1 minutes.
// - Temperature delta bits 5:3: off, 1-6 LSB threshold, or every result.
// - External voltage delta bits 2:0 behave like the temperature delta.
// - Writing one to request bit 7 pulses the PLL fault acknowledge.
// - Request bit 2 starts a one-shot external voltage conversion.
// - Request bit 1 starts a one-shot temperature conversion.
// - Request bit 0 starts a one-shot battery conversion.
// - One-shot bits clear themselves when the converter accepts the request.
// - Battery results below the threshold register raise an interrupt.
// - External voltage result register loads only on a converter interrupt.
// - Battery result register loads only on a converter interrupt.
// - Temperature result register loads only on a converter interrupt.
// - Temperature interrupt when absolute change exceeds the programmed delta.
// - Low battery interrupt sets the low battery flag for power management.
// - In battery active mode temperature and battery background runs stop.
`timescale 1ns/10ps
`default_nettype none
module aams_measurement_scheduler (
  input  wire logic       clock,
  input  wire logic       reset_n,
  input  wire logic [7:0] sfr_addr,
  input  wire logic [7:0] sfr_wdata,
  input  wire logic       sfr_write,
  input  wire logic       sfr_read,
  output var  logic [7:0] sfr_rdata,
  input  wire logic       slow_tick,
  input  wire logic       battery_active_mode,
  output var  logic [2:0] conv_req,
  input  wire logic [2:0] conv_ack,
  input  wire logic [2:0] conv_done,
  input  wire logic [7:0] batt_conv_data,
  input  wire logic [7:0] temp_conv_data,
  input  wire logic [7:0] ext_conv_data,
  output var  logic       adc_irq,
  output var  logic       low_battery_flag,
  input  wire logic       low_battery_clear,
  output var  logic       pll_fault_ack
);

  localparam int N = aams_pkg::NUM_SENSORS;

  function automatic logic write_to(
    input logic       we,
    input logic [7:0] addr,
    input logic [7:0] target
  );
    write_to = we && (addr == target);
  endfunction

  // software registers
  logic [7:0]   interval_reg;
  logic [7:0]   delta_cfg_reg;
  logic [7:0]   batt_thresh_reg;
  logic [N-1:0] oneshot_reg;
  logic [7:0]   result_reg [N];

  // time base
  logic [5:0]   sec_count_reg;
  logic         minute_pulse;

  // per-sensor sequencing
  aams_pkg::aams_conv_state_e state_reg [N];
  logic [N-1:0] src_oneshot_reg;
  logic [N-1:0] bg_pending_reg;
  logic [N-1:0] bg_strobe;
  logic [N-1:0] accepted;
  logic [N-1:0] finished;
  logic [N-1:0] result_load;
  logic [7:0]   result_value [N];
  logic [7:0]   conv_data [N];
  logic [1:0]   interval_code [N];
  logic [2:0]   delta_code [N];

  logic wr_interval;
  logic wr_delta;
  logic wr_thresh;
  logic wr_request;

  assign wr_interval = write_to(sfr_write, sfr_addr,
                                aams_pkg::INTERVAL_ADDR);
  assign wr_delta    = write_to(sfr_write, sfr_addr,
                                aams_pkg::DELTA_CFG_ADDR);
  assign wr_thresh   = write_to(sfr_write, sfr_addr,
                                aams_pkg::BATT_THRESH_ADDR);
  assign wr_request  = write_to(sfr_write, sfr_addr,
                                aams_pkg::CONV_REQUEST_ADDR);

  assign conv_data[aams_pkg::SENSOR_BATT] = batt_conv_data;
  assign conv_data[aams_pkg::SENSOR_TEMP] = temp_conv_data;
  assign conv_data[aams_pkg::SENSOR_EXT]  = ext_conv_data;

  assign interval_code[aams_pkg::SENSOR_EXT] =
    interval_reg[aams_pkg::EXT_INTERVAL_LSB +: 2];
  assign interval_code[aams_pkg::SENSOR_BATT] =
    interval_reg[aams_pkg::BATT_INTERVAL_LSB +: 2];
  assign interval_code[aams_pkg::SENSOR_TEMP] =
    interval_reg[aams_pkg::TEMP_INTERVAL_LSB +: 2];

  assign delta_code[aams_pkg::SENSOR_TEMP] =
    delta_cfg_reg[aams_pkg::TEMP_DELTA_LSB +: 3];
  assign delta_code[aams_pkg::SENSOR_EXT] =
    delta_cfg_reg[aams_pkg::EXT_DELTA_LSB +: 3];
  assign delta_code[aams_pkg::SENSOR_BATT] = aams_pkg::DELTA_OFF;

  // configuration registers; the interval register keeps its top two bits as written so a
  // read shows them, but nothing in the block looks at them; delta config clears its top two
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      interval_reg <= aams_pkg::INTERVAL_RESET;
    end else if (wr_interval) begin
      interval_reg <= sfr_wdata;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      delta_cfg_reg <= aams_pkg::DELTA_CFG_RESET;
    end else if (wr_delta) begin
      delta_cfg_reg <= sfr_wdata & aams_pkg::DELTA_USED_MASK;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      batt_thresh_reg <= aams_pkg::BATT_THRESH_RESET;
    end else if (wr_thresh) begin
      batt_thresh_reg <= sfr_wdata;
    end
  end

  // writing a zero to a request bit does not withdraw a pending request
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      oneshot_reg <= aams_pkg::CONV_REQUEST_RESET[N-1:0];
    end else begin
      for (int i = 0; i < N; i++) begin
        if (wr_request && sfr_wdata[i]) begin
          oneshot_reg[i] <= 1'b1;
        end else if (accepted[i] && src_oneshot_reg[i]) begin
          oneshot_reg[i] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      pll_fault_ack <= 1'b0;
    end else begin
      pll_fault_ack <= wr_request &&
                       sfr_wdata[aams_pkg::PLL_ACK_BIT];
    end
  end

  // one-second ticks are folded into minute pulses shared by all timers
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      sec_count_reg <= 6'h00;
      minute_pulse  <= 1'b0;
    end else begin
      minute_pulse <= 1'b0;
      if (slow_tick) begin
        if (sec_count_reg == aams_pkg::SECONDS_PER_MINUTE - 6'h01) begin
          sec_count_reg <= 6'h00;
          minute_pulse  <= 1'b1;
        end else begin
          sec_count_reg <= sec_count_reg + 6'h01;
        end
      end
    end
  end

  genvar g;
  generate
    for (g = 0; g < N; g++) begin : gen_sensor
      localparam logic [4:0] LONG_MIN =
        (g == aams_pkg::SENSOR_BATT) ? aams_pkg::BATT_LONG_MIN :
        (g == aams_pkg::SENSOR_TEMP) ? aams_pkg::TEMP_LONG_MIN :
                                       aams_pkg::EXT_LONG_MIN;
      localparam logic [4:0] MID_MIN =
        (g == aams_pkg::SENSOR_BATT) ? aams_pkg::BATT_MID_MIN :
        (g == aams_pkg::SENSOR_TEMP) ? aams_pkg::TEMP_MID_MIN :
                                       aams_pkg::EXT_MID_MIN;
      logic bg_allowed;

      // battery-powered active mode only keeps the external voltage
      // background running
      assign bg_allowed = !(battery_active_mode &&
                            (g != aams_pkg::SENSOR_EXT));

      aams_interval_timer #(
        .LONG_MIN (LONG_MIN),
        .MID_MIN  (MID_MIN)
      ) u_timer (
        .clock         (clock),
        .reset_n       (reset_n),
        .minute_pulse  (minute_pulse),
        .interval_code (interval_code[g]),
        .enable        (bg_allowed),
        .strobe        (bg_strobe[g])
      );

      assign conv_req[g] = (state_reg[g] == aams_pkg::AAMS_REQ);
      assign accepted[g] = conv_req[g] && conv_ack[g];
      assign finished[g] = (state_reg[g] == aams_pkg::AAMS_BUSY) &&
                           conv_done[g];

      // one conversion per sensor in flight; a strobe that lands while
      // busy waits here rather than being dropped
      always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
          state_reg[g]       <= aams_pkg::AAMS_IDLE;
          src_oneshot_reg[g] <= 1'b0;
        end else begin
          case (state_reg[g])
            aams_pkg::AAMS_IDLE: begin
              if (oneshot_reg[g] || bg_pending_reg[g]) begin
                state_reg[g]       <= aams_pkg::AAMS_REQ;
                src_oneshot_reg[g] <= oneshot_reg[g];
              end
            end
            aams_pkg::AAMS_REQ: begin
              if (conv_ack[g]) begin
                state_reg[g] <= aams_pkg::AAMS_BUSY;
              end
            end
            aams_pkg::AAMS_BUSY: begin
              if (conv_done[g]) begin
                state_reg[g] <= aams_pkg::AAMS_IDLE;
              end
            end
            default: begin
              state_reg[g] <= aams_pkg::AAMS_IDLE;
            end
          endcase
        end
      end

      // a one-shot taken together with a pending strobe serves both
      always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
          bg_pending_reg[g] <= 1'b0;
        end else if (!bg_allowed) begin
          // a strobe stored before battery mode began must not run later
          bg_pending_reg[g] <= 1'b0;
        end else if (bg_strobe[g]) begin
          bg_pending_reg[g] <= 1'b1;
        end else if (state_reg[g] == aams_pkg::AAMS_IDLE &&
                     (oneshot_reg[g] || bg_pending_reg[g])) begin
          bg_pending_reg[g] <= 1'b0;
        end
      end

      aams_change_tracker #(
        .THRESHOLD_MODE (g == aams_pkg::SENSOR_BATT)
      ) u_tracker (
        .clock        (clock),
        .reset_n      (reset_n),
        .done         (finished[g]),
        .from_oneshot (src_oneshot_reg[g]),
        .data         (conv_data[g]),
        .delta_code   (delta_code[g]),
        .threshold    (batt_thresh_reg),
        .load         (result_load[g]),
        .value        (result_value[g])
      );

      // hardware load wins over a software write in the same cycle
      always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
          result_reg[g] <= aams_pkg::RESULT_RESET;
        end else if (result_load[g]) begin
          result_reg[g] <= result_value[g];
        end else if (write_to(sfr_write, sfr_addr,
                              (g == aams_pkg::SENSOR_BATT) ?
                                aams_pkg::BATT_RESULT_ADDR :
                              (g == aams_pkg::SENSOR_TEMP) ?
                                aams_pkg::TEMP_RESULT_ADDR :
                                aams_pkg::EXT_RESULT_ADDR)) begin
          result_reg[g] <= sfr_wdata;
        end
      end
    end
  endgenerate

  // temperature and external voltage interrupts carry no flag of their own
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      adc_irq <= 1'b0;
    end else begin
      adc_irq <= result_load[aams_pkg::SENSOR_TEMP] ||
                 result_load[aams_pkg::SENSOR_EXT];
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      low_battery_flag <= 1'b0;
    end else if (result_load[aams_pkg::SENSOR_BATT]) begin
      low_battery_flag <= 1'b1;
    end else if (low_battery_clear) begin
      low_battery_flag <= 1'b0;
    end
  end

  // read data is registered; an unmapped address reads zero
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      sfr_rdata <= 8'h00;
    end else if (sfr_read) begin
      case (sfr_addr)
        aams_pkg::TEMP_RESULT_ADDR:
          sfr_rdata <= result_reg[aams_pkg::SENSOR_TEMP];
        aams_pkg::BATT_RESULT_ADDR:
          sfr_rdata <= result_reg[aams_pkg::SENSOR_BATT];
        aams_pkg::EXT_RESULT_ADDR:
          sfr_rdata <= result_reg[aams_pkg::SENSOR_EXT];
        aams_pkg::CONV_REQUEST_ADDR:
          sfr_rdata <= {5'h00, oneshot_reg};
        aams_pkg::DELTA_CFG_ADDR:
          sfr_rdata <= delta_cfg_reg;
        aams_pkg::INTERVAL_ADDR:
          sfr_rdata <= interval_reg;
        aams_pkg::BATT_THRESH_ADDR:
          sfr_rdata <= batt_thresh_reg;
        default:
          sfr_rdata <= 8'h00;
      endcase
    end
  end

endmodule
`default_nettype wire

// file: aams_measurement_scheduler_chk.sv
`timescale 1ns/10ps
`default_nettype none
module aams_measurement_scheduler_chk (
  input wire logic       clock,
  input wire logic       reset_n,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  input wire logic       sfr_write,
  input wire logic       sfr_read,
  input wire logic [7:0] sfr_rdata,
  input wire logic       slow_tick,
  input wire logic       battery_active_mode,
  input wire logic [2:0] conv_req,
  input wire logic [2:0] conv_ack,
  input wire logic [2:0] conv_done,
  input wire logic [7:0] batt_conv_data,
  input wire logic [7:0] temp_conv_data,
  input wire logic [7:0] ext_conv_data,
  input wire logic       adc_irq,
  input wire logic       low_battery_flag,
  input wire logic       low_battery_clear,
  input wire logic       pll_fault_ack
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!reset_n);

  logic req_wr;
  logic pll_wr;
  logic ta_done;
  assign req_wr = sfr_write && (sfr_addr == aams_pkg::CONV_REQUEST_ADDR);
  assign pll_wr = req_wr && sfr_wdata[aams_pkg::PLL_ACK_BIT];
  assign ta_done = conv_done[1] || conv_done[2];

  a_pll_ack_write: assert property (pll_wr |=> pll_fault_ack)
    else $error("pll ack missing after request write");
  a_pll_ack_cause: assert property (pll_fault_ack |-> $past(pll_wr))
    else $error("pll ack without request write");
  a_req_read_high: assert property (
    sfr_read && sfr_addr == aams_pkg::CONV_REQUEST_ADDR
    |=> sfr_rdata[7:3] == 5'h00)
    else $error("request register upper bits not zero");
  a_req_until_ack: assert property (
    conv_req[0] && !conv_ack[0] |=> conv_req[0])
    else $error("battery request dropped before accept");
  a_req_drop_ack: assert property (
    conv_req[2] && conv_ack[2] |=> !conv_req[2])
    else $error("ext request still high after accept");
  a_irq_source: assert property (adc_irq |-> $past(ta_done, 2))
    else $error("adc irq without finished conversion");
  a_flag_source: assert property (
    $rose(low_battery_flag) |-> $past(conv_done[0], 2))
    else $error("low battery flag without battery result");
  a_flag_sticky: assert property (
    low_battery_flag && !low_battery_clear |=> low_battery_flag)
    else $error("low battery flag lost without clear");

  c_irq: cover property (adc_irq);
  c_flag: cover property ($rose(low_battery_flag));
  c_pll: cover property (pll_fault_ack);
endmodule

bind aams_measurement_scheduler aams_measurement_scheduler_chk
  aams_measurement_scheduler_chk_inst (
  .clock(clock), .reset_n(reset_n), .sfr_addr(sfr_addr),
  .sfr_wdata(sfr_wdata), .sfr_write(sfr_write), .sfr_read(sfr_read),
  .sfr_rdata(sfr_rdata), .slow_tick(slow_tick),
  .battery_active_mode(battery_active_mode), .conv_req(conv_req),
  .conv_ack(conv_ack), .conv_done(conv_done),
  .batt_conv_data(batt_conv_data), .temp_conv_data(temp_conv_data),
  .ext_conv_data(ext_conv_data), .adc_irq(adc_irq),
  .low_battery_flag(low_battery_flag),
  .low_battery_clear(low_battery_clear), .pll_fault_ack(pll_fault_ack));
`default_nettype wire

// file: aams_adc_model.sv
`timescale 1ns/10ps
`default_nettype none
module aams_adc_model #(
  parameter int CONV_LEN = 6
) (
  input  wire logic       clock,
  input  wire logic       reset_n,
  input  wire logic [2:0] conv_req,
  output wire logic [2:0] conv_ack,
  output wire logic [2:0] conv_done,
  input  wire logic [7:0] batt_in,
  input  wire logic [7:0] temp_in,
  input  wire logic [7:0] ext_in,
  output wire logic [7:0] batt_conv_data,
  output wire logic [7:0] temp_conv_data,
  output wire logic [7:0] ext_conv_data
);
  // data is only meaningful with done; elsewhere it shows the inverse
  assign batt_conv_data = conv_done[0] ? batt_in : ~batt_in;
  assign temp_conv_data = conv_done[1] ? temp_in : ~temp_in;
  assign ext_conv_data  = conv_done[2] ? ext_in : ~ext_in;

  for (genvar i = 0; i < 3; i++) begin : g_sensor
    // battery accepts at once, the others keep the request waiting
    localparam int ACK_WAIT = (i == 0) ? 0 : 3;
    logic [3:0] cnt;
    logic       busy;
    logic       ack;
    logic       done;
    assign conv_ack[i]  = ack;
    assign conv_done[i] = done;
    always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
        cnt  <= 4'h0;
        busy <= 1'b0;
        ack  <= 1'b0;
        done <= 1'b0;
      end else begin
        ack  <= 1'b0;
        done <= 1'b0;
        if (!busy && conv_req[i] && !ack) begin
          if (cnt == 4'(ACK_WAIT)) begin
            ack  <= 1'b1;
            busy <= 1'b1;
            cnt  <= 4'h0;
          end else begin
            cnt <= cnt + 4'h1;
          end
        end else if (busy) begin
          if (cnt == 4'(CONV_LEN)) begin
            done <= 1'b1;
            busy <= 1'b0;
            cnt  <= 4'h0;
          end else begin
            cnt <= cnt + 4'h1;
          end
        end
      end
    end
  end
endmodule
`default_nettype wire

// file: aams_measurement_scheduler_tb.sv
`timescale 1ns/10ps
`default_nettype none
module aams_measurement_scheduler_tb;
  localparam logic [7:0] REG_ADDR [7] = '{8'hD7, 8'hD8, 8'hDF, 8'hEF,
                                          8'hF3, 8'hF9, 8'hFA};
  localparam logic [7:0] RES_ADDR [3] = '{8'hDF, 8'hD7, 8'hEF};
  // address, write data, read back
  localparam logic [23:0] ROWS [8] = '{24'hF9_2A_2A, 24'hF3_FF_3F,
    24'hFA_80_80, 24'hD7_55_55, 24'hDF_AA_AA, 24'hEF_5A_5A,
    24'h10_77_00, 24'hF9_00_00};
  // delta config, temp data, ext data, temp result, ext result
  localparam logic [39:0] DROWS [4] = '{40'h1F_45_31_42_31,
    40'h1F_46_32_46_32, 40'h1F_43_32_46_32, 40'h38_10_33_10_32};
  // battery data, flag, battery result
  localparam logic [23:0] BROWS [3] = '{24'h50_00_20, 24'h40_00_20,
                                        24'h3F_01_3F};
  localparam int BATT_MIN [4] = '{1, 16, 4, 1};
  localparam int EXT_MIN [4]  = '{1, 8, 2, 1};

  logic       clock = 1'b0;
  logic       reset_n;
  logic [7:0] sfr_addr;
  logic [7:0] sfr_wdata;
  logic       sfr_write;
  logic       sfr_read;
  logic [7:0] sfr_rdata;
  logic       slow_tick;
  logic       battery_active_mode;
  logic       low_battery_clear;
  logic [2:0] conv_req;
  logic [2:0] conv_ack;
  logic [2:0] conv_done;
  logic [7:0] batt_conv_data;
  logic [7:0] temp_conv_data;
  logic [7:0] ext_conv_data;
  logic       adc_irq;
  logic       low_battery_flag;
  logic       pll_fault_ack;
  logic [7:0] sens_d [3];
  int         n_errors = 0;
  int         samples_checked = 0;
  int         cycles = 0;
  int         irq_n = 0;
  int         pll_n = 0;
  int         n_req [3] = '{0, 0, 0};
  int         snap [3];

  always #10 clock = ~clock;

  aams_measurement_scheduler aams_measurement_scheduler_inst (
    .clock(clock), .reset_n(reset_n), .sfr_addr(sfr_addr),
    .sfr_wdata(sfr_wdata), .sfr_write(sfr_write), .sfr_read(sfr_read),
    .sfr_rdata(sfr_rdata), .slow_tick(slow_tick),
    .battery_active_mode(battery_active_mode), .conv_req(conv_req),
    .conv_ack(conv_ack), .conv_done(conv_done),
    .batt_conv_data(batt_conv_data), .temp_conv_data(temp_conv_data),
    .ext_conv_data(ext_conv_data), .adc_irq(adc_irq),
    .low_battery_flag(low_battery_flag),
    .low_battery_clear(low_battery_clear), .pll_fault_ack(pll_fault_ack));

  aams_adc_model aams_adc_model_inst (
    .clock(clock), .reset_n(reset_n), .conv_req(conv_req),
    .conv_ack(conv_ack), .conv_done(conv_done), .batt_in(sens_d[0]),
    .temp_in(sens_d[1]), .ext_in(sens_d[2]),
    .batt_conv_data(batt_conv_data), .temp_conv_data(temp_conv_data),
    .ext_conv_data(ext_conv_data));

  task automatic print_verdict();
    $display("mismatches %0d, comparisons %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic check8(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_write = 1'b1;
    @(negedge clock);
    sfr_write = 1'b0;
    @(negedge clock);
  endtask

  task automatic check_rd(input logic [7:0] a, input logic [7:0] e);
    sfr_addr = a;
    sfr_read = 1'b1;
    @(negedge clock);
    sfr_read = 1'b0;
    @(negedge clock);
    check8(sfr_rdata, e);
  endtask

  // settle time covers the slowest accept plus conversion of the model
  task automatic minutes(input int n);
    repeat (n * 60) begin
      slow_tick = 1'b1;
      @(negedge clock);
      slow_tick = 1'b0;
      @(negedge clock);
    end
    repeat (30) @(negedge clock);
  endtask

  task automatic wait_done(input int s);
    int k;
    for (k = 0; k < 60 && conv_done[s] !== 1'b1; k++) @(negedge clock);
    if (k == 60) n_errors++;
    repeat (3) @(negedge clock);
  endtask

  task automatic clear_flag();
    low_battery_clear = 1'b1;
    @(negedge clock);
    low_battery_clear = 1'b0;
  endtask

  always @(posedge clock) begin
    cycles++;
    for (int i = 0; i < 3; i++) if (conv_req[i] && conv_ack[i]) n_req[i]++;
    if (adc_irq === 1'b1) irq_n++;
    if (pll_fault_ack === 1'b1) pll_n++;
    if (cycles == 20000) begin
      n_errors++;
      print_verdict();
    end
  end

  initial begin
    reset_n = 1'b0;
    sfr_addr = 8'h00;
    sfr_wdata = 8'h00;
    sfr_write = 1'b0;
    sfr_read = 1'b0;
    slow_tick = 1'b0;
    battery_active_mode = 1'b0;
    low_battery_clear = 1'b0;
    sens_d = '{8'h20, 8'h42, 8'h30};
    repeat (20) @(negedge clock);
    reset_n = 1'b1;
    foreach (REG_ADDR[i]) check_rd(REG_ADDR[i], 8'h00);
    foreach (ROWS[i]) begin
      sfr_wr(ROWS[i][23:16], ROWS[i][15:8]);
      check_rd(ROWS[i][23:16], ROWS[i][7:0]);
    end
    sfr_wr(8'hD8, 8'h80);
    repeat (2) @(negedge clock);
    check8(8'(pll_n), 8'h01);
    check_rd(8'hD8, 8'h00);
    sfr_wr(8'hFA, 8'h00);
    for (int i = 0; i < 3; i++) begin
      sfr_wr(8'hD8, 8'h01 << i);
      check_rd(8'hD8, 8'h01 << i);
      wait_done(i);
      check_rd(8'hD8, 8'h00);
      check_rd(RES_ADDR[i], sens_d[i]);
    end
    check8({7'h00, low_battery_flag}, 8'h01);
    check8(8'(irq_n), 8'h02);
    clear_flag();
    sfr_wr(8'hF9, 8'h33);
    foreach (DROWS[i]) begin
      sfr_wr(8'hF3, DROWS[i][39:32]);
      sens_d[1] = DROWS[i][31:24];
      sens_d[2] = DROWS[i][23:16];
      minutes(1);
      check_rd(8'hD7, DROWS[i][15:8]);
      check_rd(8'hEF, DROWS[i][7:0]);
    end
    sfr_wr(8'hF9, 8'h0C);
    sfr_wr(8'hFA, 8'h40);
    foreach (BROWS[i]) begin
      sens_d[0] = BROWS[i][23:16];
      minutes(1);
      check8({7'h00, low_battery_flag}, BROWS[i][15:8]);
      check_rd(8'hDF, BROWS[i][7:0]);
      clear_flag();
    end
    battery_active_mode = 1'b1;
    sfr_wr(8'hF9, 8'h3F);
    snap = n_req;
    minutes(1);
    sfr_wr(8'hD8, 8'h02);
    wait_done(1);
    for (int i = 0; i < 3; i++) check8(8'(n_req[i] - snap[i]), 8'(i != 0));
    battery_active_mode = 1'b0;
    for (int c = 1; c < 4; c++) begin
      sfr_wr(8'hF9, 8'(c * 8'h15));
      snap = n_req;
      minutes(16);
      check8(8'(n_req[0] - snap[0]), 8'(16 / BATT_MIN[c]));
      check8(8'(n_req[1] - snap[1]), 8'(16 / EXT_MIN[c]));
      check8(8'(n_req[2] - snap[2]), 8'(16 / EXT_MIN[c]));
    end
    reset_n = 1'b0;
    @(negedge clock);
    reset_n = 1'b1;
    check_rd(8'hF9, 8'h00);
    check_rd(8'hD7, 8'h00);
    print_verdict();
  end
endmodule
`default_nettype wire
